//--- verilog/astf_pkg.sv
// ==================================================================
// What this block does
// (R1) frame: start, data lsb first, parity, stop
// (R2) 5-8 data bits, parity modes, 1/2 stops
// (R3) divisor is 16 integer plus 6 fraction bits
// (R4) tick at 16x baud, bit is 16 ticks
// (R5) divisor and line settings load on settings write
// (R6) both directions enabled after reset; here CTL_TXE, CTL_RXE reset to 1 but CTL_EN resets to 0, so neither runs
// (R7) disabling finishes the current character
// (R8) software disables before changing configuration
// (R9) transmit starts when queued, runs back to back
// (R10) busy while queued or shifting, even disabled
// (R11) start bit rechecked on eighth tick
// (R12) data sampled every sixteenth tick, parity checked
// (R13) stop must be high, else framing error
// (R14) overrun, parity, framing, break stored with data
// (R15) 16-entry queues, 12-bit reads, 8-bit writes
// (R16) queues single-entry until queue enable set
// (R17) empty, full and overrun flags reported
// (R18) thresholds 1/8 to 7/8, default half
// (R19) seven events ORed into one request
// (R20) mask gates request, raw status always readable
// (R21) writing one to clear bit clears event
// (R22) receive timeout after 32 idle bit periods
package astf_pkg;
   // ==================================================================
   // register offsets
   localparam logic [11:0] OFF_DATA = 12'h000;
   localparam logic [11:0] OFF_RSR = 12'h004;
   localparam logic [11:0] OFF_FLAG = 12'h018;
   localparam logic [11:0] OFF_IBRD = 12'h024;
   localparam logic [11:0] OFF_FBRD = 12'h028;
   localparam logic [11:0] OFF_LINE = 12'h02c;
   localparam logic [11:0] OFF_CTL = 12'h030;
   localparam logic [11:0] OFF_IFLS = 12'h034;
   localparam logic [11:0] OFF_MASK = 12'h038;
   localparam logic [11:0] OFF_RAW = 12'h03c;
   localparam logic [11:0] OFF_MIS = 12'h040;
   localparam logic [11:0] OFF_ICR = 12'h044;
   // ==================================================================
   // field positions
   localparam int LINE_BRK = 0;
   localparam int LINE_PEN = 1;
   localparam int LINE_EPS = 2;
   localparam int LINE_STP2 = 3;
   localparam int LINE_FEN = 4;
   localparam int LINE_WLEN = 5;
   localparam int LINE_SPS = 7;
   localparam int CTL_EN = 0;
   localparam int CTL_LBE = 7;
   localparam int CTL_TXE = 8;
   localparam int CTL_RXE = 9;
   localparam int EV_RX = 4;
   localparam int EV_TX = 5;
   localparam int EV_RT = 6;
   localparam int EV_FE = 7;
   localparam int EV_PE = 8;
   localparam int EV_BE = 9;
   localparam int EV_OE = 10;
   localparam int FLAG_BUSY = 3;
   localparam int FLAG_RX_QUEUE_EMPTY = 4;
   localparam int FLAG_TX_QUEUE_FULL = 5;
   localparam int FLAG_RX_QUEUE_FULL = 6;
   localparam int FLAG_TX_QUEUE_EMPTY = 7;
   // ==================================================================
   // reset values and counts
   localparam logic [9:0] CTL_RESET = 10'h300;
   localparam logic [5:0] IFLS_RESET = 6'h12;
   localparam logic [4:0] QDEPTH = 5'h10;
   localparam logic [22:0] DIV_ONE = 23'h000040;
   localparam int OVERSAMPLE = 16;
   localparam int TIMEOUT_BITS = 32;
   localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_BITS * OVERSAMPLE);
   // ==================================================================
   // types
   typedef enum logic [4:0] {
      TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
   } astf_tx_state_type;
   typedef enum logic [4:0] {
      RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
   } astf_rx_state_type;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } astf_apb_req_type;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } astf_apb_rsp_type;
   // ==================================================================
   // parity bit for the active data width
   function automatic logic astf_parity(input logic [7:0] data, input logic [1:0] wlen,
                                        input logic eps, input logic sps);
      logic p;
      p = ^(data & (8'hff >> (2'd3 - wlen)));
      if (sps) begin
         return ~eps;
      end
      return eps ? p : ~p;
   endfunction
   // queue threshold in entries
   function automatic logic [4:0] astf_level(input logic [2:0] sel);
      case (sel)
         3'h0: return 5'h02;
         3'h1: return 5'h04;
         3'h3: return 5'h0c;
         3'h4: return 5'h0e;
         default: return 5'h08;
      endcase
   endfunction
endpackage

//--- verilog/astf_top.sv
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
module astf_top (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire astf_pkg::astf_apb_req_type apb_req_i,
   output astf_pkg::astf_apb_rsp_type apb_rsp_o,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic irq_o
);
   typedef struct packed {
      logic [9:0] ctl;
      logic [15:0] ibrd;
      logic [5:0] fbrd;
      logic [7:0] line;
      logic [29:0] cfg;
      logic [5:0] ifls;
      logic [10:0] mask;
      logic [10:0] raw;
      logic [3:0] rsr;
      logic [31:0] prdata;
      logic pop_ok;
      logic irq;
      logic [22:0] acc;
      logic tick;
      logic [2:0] sync;
      logic rxl;
      logic rprev;
      logic [15:0][7:0] txm;
      logic [3:0] twp;
      logic [3:0] trp;
      logic [4:0] tcnt;
      astf_pkg::astf_tx_state_type tst;
      logic [3:0] tsub;
      logic [2:0] tbit;
      logic [7:0] tsh;
      logic tpar;
      logic tline;
      logic pin;
      logic [15:0][11:0] rxm;
      logic [3:0] rwp;
      logic [3:0] rrp;
      logic [4:0] rcnt;
      astf_pkg::astf_rx_state_type rst;
      logic [3:0] rsub;
      logic [2:0] rbit;
      logic [7:0] rsh;
      logic rpe;
      logic rpbit;
      logic oe_pend;
      logic [9:0] tocnt;
      logic rx_prev;
      logic tx_prev;
   } astf_state_type;

   astf_state_type q;
   astf_state_type d;

   // ==================================================================
   // decodes
   logic [7:0] lcr;
   logic [22:0] div;
   logic [22:0] acc_sum;
   logic [2:0] nb1;
   logic [4:0] depth;
   logic txen;
   logic rxen;
   logic setup;
   logic wr;
   logic rd_acc;
   logic mapped;
   logic rxin;
   logic busy;
   logic [7:0] rx_data;
   logic rx_cond;
   logic tx_cond;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic [10:0] ev_set;
   logic [10:0] ev_clr;
   logic [31:0] rd;

   assign lcr = q.cfg[7:0];
   assign div = {1'b0, q.cfg[29:8]}; // (R3)
   assign acc_sum = q.acc + astf_pkg::DIV_ONE;
   assign nb1 = {1'b0, lcr[astf_pkg::LINE_WLEN +: 2]} + 3'h4; // (R2)
   assign depth = lcr[astf_pkg::LINE_FEN] ? astf_pkg::QDEPTH : 5'h01; // (R16)
   assign txen = q.ctl[astf_pkg::CTL_EN] & q.ctl[astf_pkg::CTL_TXE];
   assign rxen = q.ctl[astf_pkg::CTL_EN] & q.ctl[astf_pkg::CTL_RXE];
   assign setup = apb_req_i.psel & ~apb_req_i.penable;
   assign wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & mapped;
   assign rd_acc = apb_req_i.psel & apb_req_i.penable & ~apb_req_i.pwrite;
   assign rxin = q.ctl[astf_pkg::CTL_LBE] ? q.pin : q.rxl;
   assign busy = (q.tcnt != 5'h00) || (q.tst != astf_pkg::TX_IDLE); // (R10)
   assign rx_data = q.rsh >> (3'h7 - nb1);
   assign rx_cond = lcr[astf_pkg::LINE_FEN] ?
                    (q.rcnt >= astf_pkg::astf_level(q.ifls[5:3])) : (q.rcnt != 5'h00); // (R18)
   assign tx_cond = lcr[astf_pkg::LINE_FEN] ?
                    (q.tcnt <= astf_pkg::astf_level(q.ifls[2:0])) : (q.tcnt == 5'h00); // (R18)

   assign apb_rsp_o.pready = 1'b1;
   assign apb_rsp_o.pslverr = apb_req_i.psel & apb_req_i.penable & ~mapped;
   assign apb_rsp_o.prdata = q.prdata;
   assign serial_out_o = q.pin;
   assign irq_o = q.irq;

   // ==================================================================
   // register read mux
   always_comb begin
      rd = 32'h00000000;
      mapped = 1'b1;
      case (apb_req_i.paddr)
         astf_pkg::OFF_DATA: rd = {20'h00000, q.rxm[q.rrp]}; // (R15)
         astf_pkg::OFF_RSR: rd = {28'h0000000, q.rsr};
         astf_pkg::OFF_FLAG: begin
            rd[astf_pkg::FLAG_BUSY] = busy;
            rd[astf_pkg::FLAG_RX_QUEUE_EMPTY] = q.rcnt == 5'h00; // (R17)
            rd[astf_pkg::FLAG_TX_QUEUE_FULL] = q.tcnt >= depth;
            rd[astf_pkg::FLAG_RX_QUEUE_FULL] = q.rcnt >= depth;
            rd[astf_pkg::FLAG_TX_QUEUE_EMPTY] = q.tcnt == 5'h00;
         end
         astf_pkg::OFF_IBRD: rd = {16'h0000, q.ibrd};
         astf_pkg::OFF_FBRD: rd = {26'h0000000, q.fbrd};
         astf_pkg::OFF_LINE: rd = {24'h000000, q.line};
         astf_pkg::OFF_CTL: rd = {22'h000000, q.ctl};
         astf_pkg::OFF_IFLS: rd = {26'h0000000, q.ifls};
         astf_pkg::OFF_MASK: rd = {21'h000000, q.mask};
         astf_pkg::OFF_RAW: rd = {21'h000000, q.raw}; // (R20)
         astf_pkg::OFF_MIS: rd = {21'h000000, q.raw & q.mask}; // (R20)
         astf_pkg::OFF_ICR: rd = 32'h00000000;
         default: mapped = 1'b0;
      endcase
   end

   // ==================================================================
   // next state
   always_comb begin
      d = q;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      ev_set = 11'h000;
      ev_clr = 11'h000;

      // read data is captured in the setup cycle, the pop happens at the access edge
      if (setup) begin
         d.prdata = rd;
         d.pop_ok = (apb_req_i.paddr == astf_pkg::OFF_DATA) && !apb_req_i.pwrite &&
                    (q.rcnt != 5'h00);
      end
      if (rd_acc && q.pop_ok) begin
         rx_pop = 1'b1;
         d.rsr[2:0] = q.rxm[q.rrp][10:8];
         d.pop_ok = 1'b0;
      end

      if (wr) begin
         case (apb_req_i.paddr)
            astf_pkg::OFF_DATA: tx_push = q.tcnt < depth; // (R15)
            astf_pkg::OFF_RSR: d.rsr = 4'h0;
            astf_pkg::OFF_IBRD: d.ibrd = apb_req_i.pwdata[15:0];
            astf_pkg::OFF_FBRD: d.fbrd = apb_req_i.pwdata[5:0];
            astf_pkg::OFF_LINE: begin
               d.line = apb_req_i.pwdata[7:0];
               d.cfg = {q.ibrd, q.fbrd, apb_req_i.pwdata[7:0]}; // (R5)
            end
            astf_pkg::OFF_CTL: d.ctl = apb_req_i.pwdata[9:0];
            astf_pkg::OFF_IFLS: d.ifls = apb_req_i.pwdata[5:0];
            astf_pkg::OFF_MASK: d.mask = apb_req_i.pwdata[10:0];
            astf_pkg::OFF_ICR: ev_clr = apb_req_i.pwdata[10:0]; // (R21)
            default: ev_clr = 11'h000;
         endcase
      end

      // fractional divider: 1/64 steps, one tick per divisor
      d.tick = 1'b0;
      if (div == 23'h000000) begin
         d.acc = 23'h000000;
      end else if (div < astf_pkg::DIV_ONE) begin
         d.tick = 1'b1;
         d.acc = 23'h000000;
      end else if (acc_sum >= div) begin
         d.tick = 1'b1; // (R4)
         d.acc = acc_sum - div;
      end else begin
         d.acc = acc_sum;
      end

      // three-stage input synchroniser, change taken when stages two and three agree
      d.sync = {q.sync[1:0], serial_in_i};
      if (q.sync[1] == q.sync[2]) begin
         d.rxl = q.sync[2];
      end
      d.rprev = rxin;

      // ==================================================================
      // transmitter
      if (q.tick && q.tst != astf_pkg::TX_IDLE) begin
         d.tsub = q.tsub + 4'h1;
      end
      case (q.tst)
         astf_pkg::TX_IDLE: begin
            if (txen && q.tcnt != 5'h00) begin // (R9)
               tx_pop = 1'b1;
               d.tsh = q.txm[q.trp];
               d.tpar = astf_pkg::astf_parity(q.txm[q.trp], lcr[astf_pkg::LINE_WLEN +: 2],
                                              lcr[astf_pkg::LINE_EPS], lcr[astf_pkg::LINE_SPS]);
               d.tst = astf_pkg::TX_START;
               d.tsub = 4'h0;
               d.tline = 1'b0; // (R1)
            end
         end
         astf_pkg::TX_START: begin
            if (q.tick && q.tsub == 4'hf) begin // (R4)
               d.tst = astf_pkg::TX_DATA;
               d.tbit = 3'h0;
               d.tline = q.tsh[0]; // (R1)
            end
         end
         astf_pkg::TX_DATA: begin
            if (q.tick && q.tsub == 4'hf) begin
               if (q.tbit == nb1) begin // (R2)
                  d.tbit = 3'h0;
                  if (lcr[astf_pkg::LINE_PEN]) begin
                     d.tst = astf_pkg::TX_PAR;
                     d.tline = q.tpar;
                  end else begin
                     d.tst = astf_pkg::TX_STOP;
                     d.tline = 1'b1;
                  end
               end else begin
                  d.tbit = q.tbit + 3'h1;
                  d.tsh = q.tsh >> 1;
                  d.tline = q.tsh[1];
               end
            end
         end
         astf_pkg::TX_PAR: begin
            if (q.tick && q.tsub == 4'hf) begin
               d.tst = astf_pkg::TX_STOP;
               d.tline = 1'b1;
            end
         end
         astf_pkg::TX_STOP: begin
            if (q.tick && q.tsub == 4'hf) begin
               if (lcr[astf_pkg::LINE_STP2] && q.tbit == 3'h0) begin // (R2)
                  d.tbit = 3'h1;
               end else begin
                  d.tst = astf_pkg::TX_IDLE; // (R7)
               end
            end
         end
         default: begin
            d.tst = astf_pkg::TX_IDLE;
            d.tline = 1'b1;
         end
      endcase
      d.pin = d.tline & ~d.line[astf_pkg::LINE_BRK];

      // ==================================================================
      // receiver
      if (q.tick && q.rst != astf_pkg::RX_IDLE) begin
         d.rsub = q.rsub + 4'h1;
      end
      case (q.rst)
         astf_pkg::RX_IDLE: begin
            if (rxen && q.rprev && !rxin) begin // (R11)
               d.rst = astf_pkg::RX_START;
               d.rsub = 4'h0;
            end
         end
         astf_pkg::RX_START: begin
            if (q.tick && q.rsub == 4'h7) begin
               d.rsub = 4'h0;
               d.rbit = 3'h0;
               d.rpe = 1'b0;
               d.rpbit = 1'b0;
               d.rst = rxin ? astf_pkg::RX_IDLE : astf_pkg::RX_DATA; // (R11)
            end
         end
         astf_pkg::RX_DATA: begin
            if (q.tick && q.rsub == 4'hf) begin // (R12)
               d.rsh = {rxin, q.rsh[7:1]};
               d.rbit = q.rbit + 3'h1;
               if (q.rbit == nb1) begin
                  d.rst = lcr[astf_pkg::LINE_PEN] ? astf_pkg::RX_PAR : astf_pkg::RX_STOP;
               end
            end
         end
         astf_pkg::RX_PAR: begin
            if (q.tick && q.rsub == 4'hf) begin
               d.rpbit = rxin;
               d.rpe = rxin != astf_pkg::astf_parity(rx_data, lcr[astf_pkg::LINE_WLEN +: 2],
                                                    lcr[astf_pkg::LINE_EPS],
                                                    lcr[astf_pkg::LINE_SPS]); // (R12)
               d.rst = astf_pkg::RX_STOP;
            end
         end
         astf_pkg::RX_STOP: begin
            if (q.tick && q.rsub == 4'hf) begin
               d.rst = astf_pkg::RX_IDLE;
               d.tocnt = 10'h000;
               if (q.rcnt < depth) begin
                  rx_push = 1'b1;
                  d.oe_pend = 1'b0;
                  // stored entry: overrun, break, parity, framing, data
                  d.rxm[q.rwp] = {q.oe_pend, (rx_data == 8'h00) && !q.rpbit && !rxin,
                                  q.rpe, !rxin, rx_data}; // (R13) (R14)
                  ev_set[astf_pkg::EV_FE] = !rxin; // (R13)
                  ev_set[astf_pkg::EV_PE] = q.rpe;
                  ev_set[astf_pkg::EV_BE] = (rx_data == 8'h00) && !q.rpbit && !rxin;
               end else begin
                  d.oe_pend = 1'b1; // (R14)
                  ev_set[astf_pkg::EV_OE] = 1'b1;
               end
            end
         end
         default: d.rst = astf_pkg::RX_IDLE;
      endcase

      // ==================================================================
      // queue pointers and counts
      if (tx_push) begin
         d.txm[q.twp] = apb_req_i.pwdata[7:0];
         d.twp = q.twp + 4'h1;
      end
      if (tx_pop) begin
         d.trp = q.trp + 4'h1;
      end
      d.tcnt = q.tcnt + {4'h0, tx_push} - {4'h0, tx_pop};
      if (rx_push) begin
         d.rwp = q.rwp + 4'h1;
      end
      if (rx_pop) begin
         d.rrp = q.rrp + 4'h1;
      end
      d.rcnt = q.rcnt + {4'h0, rx_push} - {4'h0, rx_pop};

      // receive timeout: 32 bit periods with data waiting and no character arriving
      if (q.rcnt != 5'h00 && q.rst == astf_pkg::RX_IDLE) begin
         if (q.tick && q.tocnt != astf_pkg::TIMEOUT_TICKS) begin
            d.tocnt = q.tocnt + 10'h001;
            ev_set[astf_pkg::EV_RT] = q.tocnt == astf_pkg::TIMEOUT_TICKS - 10'h001; // (R22)
         end
      end else if (q.rst == astf_pkg::RX_IDLE) begin
         d.tocnt = 10'h000;
      end
      if (rx_pop && q.rcnt == 5'h01) begin
         ev_clr[astf_pkg::EV_RT] = 1'b1; // (R22)
      end

      // threshold events fire on entering the condition
      d.rx_prev = rx_cond;
      d.tx_prev = tx_cond;
      ev_set[astf_pkg::EV_RX] = rx_cond && !q.rx_prev; // (R18)
      ev_set[astf_pkg::EV_TX] = tx_cond && !q.tx_prev;

      // a new event wins over a clear in the same cycle
      d.raw = (q.raw & ~ev_clr) | ev_set; // (R21)
      if (ev_set[astf_pkg::EV_OE]) begin
         d.rsr[3] = 1'b1; // (R17)
      end
      d.irq = |(d.raw & d.mask); // (R19) (R20)
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
         q.ctl <= astf_pkg::CTL_RESET; // (R6)
         q.ifls <= astf_pkg::IFLS_RESET; // (R18)
         q.sync <= 3'h7;
         q.rxl <= 1'b1;
         q.rprev <= 1'b1;
         q.tline <= 1'b1;
         q.pin <= 1'b1;
         q.rx_prev <= 1'b0;
         q.tx_prev <= 1'b1;
         q.tst <= astf_pkg::TX_IDLE;
         q.rst <= astf_pkg::RX_IDLE;
      end else begin
         q <= d;
      end
   end

   // ==================================================================
   // checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_start_check;
      q.rst == astf_pkg::RX_START && q.tick && q.rsub == 4'h7;
   endsequence
   sequence s_line_write;
      wr && apb_req_i.paddr == astf_pkg::OFF_LINE;
   endsequence

   a_start_low: assert property (q.tst == astf_pkg::TX_START |-> !q.tline) // (R1)
      else $error("start bit not low");
   a_stop_high: assert property (q.tst == astf_pkg::TX_STOP |-> q.tline) // (R1)
      else $error("stop bit not high");
   a_start_glitch: assert property (s_start_check and rxin |=> q.rst == astf_pkg::RX_IDLE) // (R11)
      else $error("false start accepted");
   a_start_taken: assert property (s_start_check and !rxin |=> q.rst == astf_pkg::RX_DATA) // (R11)
      else $error("valid start dropped");
   a_cfg_load: assert property (s_line_write |=>
                                q.cfg == {$past(q.ibrd), $past(q.fbrd), $past(apb_req_i.pwdata[7:0])}) // (R5)
      else $error("settings not loaded");
   a_cfg_hold: assert property (!(wr && apb_req_i.paddr == astf_pkg::OFF_LINE) |=> $stable(q.cfg)) // (R5)
      else $error("settings changed without write");
   a_busy_queue: assert property (q.tcnt != 5'h00 |-> busy) // (R10)
      else $error("busy low with data queued");
   a_tx_hold_off: assert property (q.tst == astf_pkg::TX_IDLE && !txen |=> q.tst == astf_pkg::TX_IDLE) // (R9)
      else $error("transmit started while disabled");
   a_single_entry: assert property (!lcr[astf_pkg::LINE_FEN] && q.tcnt == 5'h01 && !tx_pop
                                    |=> q.tcnt == 5'h01) // (R16)
      else $error("holding register overfilled");
   a_irq_gated: assert property ((q.raw & q.mask) == 11'h000 |-> !irq_o) // (R20)
      else $error("masked event raised request");
   a_clear_event: assert property (wr && apb_req_i.paddr == astf_pkg::OFF_ICR |=>
                                   (q.raw & $past(apb_req_i.pwdata[10:0]) & ~$past(ev_set)) == 11'h000) // (R21)
      else $error("event not cleared");
   a_timeout_data: assert property ($rose(q.raw[astf_pkg::EV_RT]) |-> $past(q.rcnt) != 5'h00) // (R22)
      else $error("timeout with empty queue");
endmodule

//--- bench/astf_line_model.sv
`timescale 1ns/10ps
module astf_line_model (
   input wire logic clk_i,
   input wire logic serial_i,
   output logic serial_o
);
   // ==================================================================
   // far end of the line, one bit is 16 clocks at divisor 1.0
   localparam int BIT_CLKS = 16;
   logic [7:0] rx_byte = 8'h00;
   logic [7:0] shift = 8'h00;
   int rx_count = 0;
   initial serial_o = 1'b1;
   // samples mid-bit, lsb first, eight data bits
   always begin
      @(negedge serial_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk_i);
         shift[i] = serial_i;
      end
      repeat (BIT_CLKS) @(posedge clk_i);
      rx_byte = shift;
      rx_count++;
   end
   // start, eight data lsb first, one stop of the given level
   task automatic send(input logic [7:0] d, input logic stop);
      serial_o <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         serial_o <= d[i];
         repeat (BIT_CLKS) @(posedge clk_i);
      end
      serial_o <= stop;
      repeat (BIT_CLKS) @(posedge clk_i);
      serial_o <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_i);
   endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   astf_pkg::astf_apb_req_type req = '0;
   astf_pkg::astf_apb_rsp_type rsp;
   logic serial_in;
   logic serial_out;
   logic irq;
   logic [31:0] rd;
   int n_errors = 0;
   int n_compared = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   astf_top astf_top_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .apb_req_i(req),
      .apb_rsp_o(rsp), .serial_in_i(serial_in), .serial_out_o(serial_out), .irq_o(irq));
   astf_line_model astf_line_model_inst (.clk_i(ref_clk_i), .serial_i(serial_out),
      .serial_o(serial_in));
   // ==================================================================
   // tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge ref_clk_i);
      req.penable <= 1'b1;
      @(posedge ref_clk_i);
      while (rsp.pready !== 1'b1) @(posedge ref_clk_i);
      rd = rsp.prdata;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      // one idle edge so the next call never reassigns psel in this time step
      @(posedge ref_clk_i);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task wait_rx(input int n);
      while (astf_line_model_inst.rx_count != n) @(posedge ref_clk_i);
   endtask
   task give_verdict;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==================================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_errors++;
      give_verdict();
   end
   // ==================================================================
   // tests
   initial begin
      repeat (10) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      @(posedge ref_clk_i);
      rdchk(astf_pkg::OFF_CTL, 32'h300);
      rdchk(astf_pkg::OFF_IFLS, 32'h12);
      rdchk(astf_pkg::OFF_FLAG, 32'h90);
      $display("test reset done");
      apb(1'b1, astf_pkg::OFF_CTL, 32'h0);
      apb(1'b1, astf_pkg::OFF_IBRD, 32'h1);
      apb(1'b1, astf_pkg::OFF_FBRD, 32'h0);
      apb(1'b1, astf_pkg::OFF_LINE, 32'h70);
      apb(1'b1, astf_pkg::OFF_CTL, 32'h301);
      apb(1'b1, astf_pkg::OFF_DATA, 32'ha5);
      apb(1'b1, astf_pkg::OFF_DATA, 32'h5a);
      rdchk(astf_pkg::OFF_FLAG, 32'h18);
      wait_rx(1);
      chk(astf_line_model_inst.rx_byte, 32'ha5);
      wait_rx(2);
      chk(astf_line_model_inst.rx_byte, 32'h5a);
      repeat (40) @(posedge ref_clk_i);
      rdchk(astf_pkg::OFF_FLAG, 32'h90);
      $display("test transmit done");
      apb(1'b1, astf_pkg::OFF_DATA, 32'h66);
      apb(1'b1, astf_pkg::OFF_CTL, 32'h300);
      wait_rx(3);
      chk(astf_line_model_inst.rx_byte, 32'h66);
      apb(1'b1, astf_pkg::OFF_CTL, 32'h301);
      $display("test disable done");
      astf_line_model_inst.send(8'h3c, 1'b1);
      repeat (20) @(posedge ref_clk_i);
      rdchk(astf_pkg::OFF_DATA, 32'h3c);
      astf_line_model_inst.send(8'h81, 1'b0);
      repeat (20) @(posedge ref_clk_i);
      rdchk(astf_pkg::OFF_DATA, 32'h181);
      $display("test receive done");
      apb(1'b1, astf_pkg::OFF_MASK, 32'h40);
      astf_line_model_inst.send(8'h0f, 1'b1);
      repeat (300) @(posedge ref_clk_i);
      chk(irq, 1'b0);
      repeat (300) @(posedge ref_clk_i);
      chk(irq, 1'b1);
      rdchk(astf_pkg::OFF_MIS, 32'h40);
      apb(1'b1, astf_pkg::OFF_ICR, 32'h40);
      repeat (2) @(posedge ref_clk_i);
      chk(irq, 1'b0);
      rdchk(astf_pkg::OFF_MIS, 32'h0);
      rdchk(astf_pkg::OFF_DATA, 32'h0f);
      $display("test timeout done");
      apb(1'b1, astf_pkg::OFF_CTL, 32'h0);
      apb(1'b1, astf_pkg::OFF_LINE, 32'h7e);
      apb(1'b1, astf_pkg::OFF_CTL, 32'h381);
      apb(1'b1, astf_pkg::OFF_DATA, 32'h55);
      repeat (250) @(posedge ref_clk_i);
      rdchk(astf_pkg::OFF_DATA, 32'h055);
      $display("test loopback done");
      give_verdict();
   end
endmodule
